// ---- logic/usb_power_frame_irq_ctrl.sv ----
// Strobed register access was decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Iso wait clear: send on next IN
// - Iso wait set: hold packet until SOF
// - IN before SOF gets zero-length packet
// - One iso wait bit for all endpoints
// - Inhibit set at reset; power resets 0x10
// - Writing one to inhibit does nothing
// - Inhibit set ignores all bus traffic
// - Writing reset bit forces controller reset
// - Reset bit reads bus reset status
// - Resume write while suspended drives wakeup
// - Resume cleared: interrupt, leave suspend
// - Suspended flag shows suspend mode
// - Common flag read after resume clears suspend
// - Suspend detect off: never suspend
// - Suspend detect on: enter suspend
// - Frame number split low/high registers
// - Frame high upper bits zero, reset zero
// - Interrupt when any flag set
// - Reading flag register clears it
// - IN flags in bits 3..0, upper zero
// - Suspend interrupt only when enabled
// - Bus resume leaves suspend mode at next common flag read
module usb_power_frame_irq_ctrl #(
  parameter int EPS = usb_power_pkg::EP_N
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [usb_power_pkg::ADDR_W-1:0] ADDR,
  input wire logic [usb_power_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [usb_power_pkg::DATA_W-1:0] RDATA,
  input wire logic [EPS-1:0] IN_PACKET_READY,
  input wire usb_power_pkg::link_in_t LINK_IN,
  output usb_power_pkg::link_out_t LINK_OUT,
  output logic IRQ
);
  import usb_power_pkg::*;

  link_in_t sync1_q, sync2_q, prev_q;
  logic iso_q, inh_q, resume_q, susp_q, suspend_detect_enable_q, soft_rst_q, rsu_seen_q;
  logic [FRAME_W-1:0] frame_q;
  logic [EP_N-1:0] in_flags_q;
  logic [3:0] cm_flags_q, cm_en_q;
  logic [DATA_W-1:0] power_rd;
  logic [EP_N-1:0] ev_in, ev_tok, send_d, zero_d;
  logic ev_sof, ev_rst, ev_sus, ev_rsu, ev_wake_end, rd_cm, rd_in, wr_pw, rst_all;
  link_in_t live;

  // Bus pins pass two flops first
  always_ff @(posedge CLOCK) begin
    sync1_q <= LINK_IN;
    sync2_q <= sync1_q;
    prev_q <= sync2_q;
  end

  assign rst_all = RESET | soft_rst_q;
  assign wr_pw = WR && ADDR == OFS_POWER;
  assign rd_cm = RD && ADDR == OFS_COMMON;
  assign rd_in = RD && ADDR == OFS_IN_FLAGS;

  always_comb begin
    live = sync2_q;
    if (inh_q) begin
      live = '0;
    end
  end

  assign ev_sof = live.sof && !prev_q.sof;
  assign ev_rst = live.bus_reset && !prev_q.bus_reset;
  assign ev_sus = live.bus_suspend && !prev_q.bus_suspend && suspend_detect_enable_q && !susp_q;
  assign ev_rsu = live.bus_resume && !prev_q.bus_resume && susp_q;
  assign ev_in = live.ep_done & ~prev_q.ep_done;
  // One answer per token, however long the token level stands
  assign ev_tok = live.in_token & ~prev_q.in_token;
  assign ev_wake_end = wr_pw && resume_q && !WDATA[BIT_RESUME];

  // Forced reset pulse lasts one cycle
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_pw && WDATA[BIT_RST] && !soft_rst_q;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      inh_q <= POWER_RESET[BIT_INH];
      iso_q <= POWER_RESET[BIT_ISO];
      suspend_detect_enable_q <= POWER_RESET[BIT_SUSPEND_DETECT_ENABLE];
    end else if (wr_pw) begin
      iso_q <= WDATA[BIT_ISO];
      suspend_detect_enable_q <= WDATA[BIT_SUSPEND_DETECT_ENABLE];
      if (!WDATA[BIT_INH]) begin
        inh_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      resume_q <= 1'b0;
    end else if (wr_pw) begin
      if (!WDATA[BIT_RESUME]) begin
        resume_q <= 1'b0;
      end else if (susp_q) begin
        resume_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      susp_q <= 1'b0;
      rsu_seen_q <= 1'b0;
    end else begin
      if (ev_sus) begin
        susp_q <= 1'b1;
      end else if (ev_wake_end || (rd_cm && rsu_seen_q) || ev_rst) begin
        susp_q <= 1'b0;
      end
      if (ev_rsu) begin
        rsu_seen_q <= 1'b1;
      end else if (rd_cm) begin
        rsu_seen_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      frame_q <= '0;
    end else if (ev_sof) begin
      frame_q <= live.frame;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      in_flags_q <= '0;
    end else begin
      in_flags_q <= (rd_in ? '0 : in_flags_q) | ev_in;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      cm_flags_q <= '0;
    end else begin
      cm_flags_q <= (rd_cm ? 4'h0 : cm_flags_q)
        | {ev_sof, ev_rst, ev_rsu || ev_wake_end, ev_sus && cm_en_q[CM_SUS]};
    end
  end

  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      cm_en_q <= COMMON_EN_RESET[3:0];
    end else if (WR && ADDR == OFS_COMMON_EN) begin
      cm_en_q <= WDATA[3:0];
    end
  end

  always_comb begin
    power_rd = '0;
    power_rd[BIT_ISO] = iso_q;
    power_rd[BIT_INH] = inh_q;
    power_rd[BIT_RST] = live.bus_reset;
    power_rd[BIT_RESUME] = resume_q;
    power_rd[BIT_SUSP] = susp_q;
    power_rd[BIT_SUSPEND_DETECT_ENABLE] = suspend_detect_enable_q;
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      RDATA <= '0;
    end else if (RD) begin
      case (ADDR)
        OFS_POWER: RDATA <= power_rd;
        OFS_IN_FLAGS: RDATA <= pad8(in_flags_q);
        OFS_COMMON: RDATA <= pad8(cm_flags_q);
        OFS_COMMON_EN: RDATA <= pad8(cm_en_q);
        OFS_FRAME_LOW: RDATA <= frame_q[DATA_W-1:0];
        OFS_FRAME_HIGH: RDATA <= {5'h00, frame_q[FRAME_W-1:DATA_W]};
        default: RDATA <= '0;
      endcase
    end else begin
      RDATA <= '0;
    end
  end

  // Flag set lands on IRQ one cycle later
  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |in_flags_q || |cm_flags_q;
    end
  end

  genvar g;
  for (g = 0; g < EP_N; g++) begin : gen_iso
    iso_in_gate u_gate (
      .clk(CLOCK),
      .rst(rst_all),
      .wait_sof(iso_q),
      .ready(IN_PACKET_READY[g]),
      .sof(ev_sof),
      .in_token(ev_tok[g]),
      .send_data(send_d[g]),
      .send_zero(zero_d[g])
    );
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      LINK_OUT <= '0;
    end else begin
      LINK_OUT.send_data <= send_d;
      LINK_OUT.send_zero <= zero_d;
      LINK_OUT.drive_resume <= resume_q;
      LINK_OUT.link_enable <= !inh_q;
      LINK_OUT.core_reset <= soft_rst_q;
    end
  end
endmodule : usb_power_frame_irq_ctrl

// ---- pkg/usb_power_pkg.sv ----
package usb_power_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int FRAME_W = 11;
  localparam int EP_N = 4;
  localparam int CLK_KHZ = 25000;
  localparam logic [ADDR_W-1:0] OFS_POWER = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_IN_FLAGS = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_COMMON = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_FRAME_LOW = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_FRAME_HIGH = 8'h0D;
  localparam logic [ADDR_W-1:0] OFS_COMMON_EN = 8'h0B;
  localparam logic [DATA_W-1:0] POWER_RESET = 8'h10;
  localparam logic [DATA_W-1:0] COMMON_EN_RESET = 8'h06;
  localparam int BIT_ISO = 7;
  localparam int BIT_INH = 4;
  localparam int BIT_RST = 3;
  localparam int BIT_RESUME = 2;
  localparam int BIT_SUSP = 1;
  localparam int BIT_SUSPEND_DETECT_ENABLE = 0;
  localparam int CM_SOF = 3;
  localparam int CM_RST = 2;
  localparam int CM_RSU = 1;
  localparam int CM_SUS = 0;
  localparam int FRAME_HI_W = 3;

  typedef struct packed {
    logic sof;
    logic [FRAME_W-1:0] frame;
    logic bus_reset;
    logic bus_suspend;
    logic bus_resume;
    logic [EP_N-1:0] in_token;
    logic [EP_N-1:0] ep_done;
  } link_in_t;

  typedef struct packed {
    logic [EP_N-1:0] send_data;
    logic [EP_N-1:0] send_zero;
    logic drive_resume;
    logic link_enable;
    logic core_reset;
  } link_out_t;

  typedef enum logic [1:0] {
    ISO_IDLE = 2'b00,
    ISO_ARMED = 2'b01,
    ISO_GO = 2'b11
  } iso_state_t;

  function automatic logic [DATA_W-1:0] pad8(input logic [3:0] v);
    return {4'h0, v};
  endfunction : pad8
endpackage : usb_power_pkg

// ---- logic/iso_in_gate.sv ----
`timescale 1ns/1ps
module iso_in_gate (
  input wire logic clk,
  input wire logic rst,
  input wire logic wait_sof,
  input wire logic ready,
  input wire logic sof,
  input wire logic in_token,
  output logic send_data,
  output logic send_zero
);
  import usb_power_pkg::*;
  iso_state_t state_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ISO_IDLE;
    end else begin
      case (state_q)
        ISO_IDLE: if (ready) state_q <= wait_sof ? ISO_ARMED : ISO_GO;
        ISO_ARMED: if (sof) state_q <= ISO_GO;
        ISO_GO: if (in_token) state_q <= ISO_IDLE;
        default: state_q <= ISO_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      send_data <= 1'b0;
      send_zero <= 1'b0;
    end else begin
      send_data <= in_token && state_q == ISO_GO;
      send_zero <= in_token && state_q != ISO_GO;
    end
  end
endmodule : iso_in_gate

// ---- verif/power_ctrl_props.sv ----
`timescale 1ns/1ps
module power_ctrl_props
  import usb_power_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [DATA_W-1:0] RDATA,
  input wire usb_power_pkg::link_out_t LINK_OUT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  reset_inhibit_a: assert property ($fell(RESET) |-> !LINK_OUT.link_enable)
    else $error("link enabled after reset");
  rst_inhibit_a: assert property (LINK_OUT.core_reset
    |-> ##[0:2] !LINK_OUT.link_enable) else $error("inhibit not set");
  rst_pulse_a: assert property (WR && ADDR == OFS_POWER && WDATA[BIT_RST]
    |-> ##[1:2] LINK_OUT.core_reset) else $error("no core reset");
  set_ignored_a: assert property (WR && ADDR == OFS_POWER && WDATA[BIT_INH]
    && !WDATA[BIT_RST] && LINK_OUT.link_enable |=> LINK_OUT.link_enable)
    else $error("inhibit set by write");
  frame_high_a: assert property ($past(RD) && $past(ADDR) == OFS_FRAME_HIGH
    |-> RDATA[7:3] == 5'h00) else $error("frame high bits");
  in_flags_a: assert property ($past(RD) && $past(ADDR) == OFS_IN_FLAGS
    |-> RDATA[7:4] == 4'h0) else $error("in flags bits");
  inhibit_quiet_a: assert property (!LINK_OUT.link_enable
    |-> LINK_OUT.send_data == 4'h0) else $error("send while inhibited");
  send_excl_a: assert property ((LINK_OUT.send_data & LINK_OUT.send_zero) == 4'h0)
    else $error("data and zero together");
  cover property (LINK_OUT.send_zero != 4'h0);
  cover property (LINK_OUT.drive_resume);
  cover property (LINK_OUT.core_reset);
endmodule : power_ctrl_props

bind usb_power_frame_irq_ctrl power_ctrl_props power_ctrl_props_inst (.CLOCK(CLOCK),
  .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .LINK_OUT(LINK_OUT));

// ---- verif/usb_host_model.sv ----
`timescale 1ns/1ps
module usb_host_model
  import usb_power_pkg::*;
(
  input wire logic CLOCK,
  input wire usb_power_pkg::link_out_t LINK_OUT,
  output usb_power_pkg::link_in_t LINK_IN
);
  logic [EP_N-1:0] got_data = '0;
  logic [EP_N-1:0] got_zero = '0;
  initial LINK_IN = '0;
  // Answers seen so far, never cleared
  always @(posedge CLOCK) begin
    got_data <= got_data | LINK_OUT.send_data;
    got_zero <= got_zero | LINK_OUT.send_zero;
  end
  // Raise event lines for n cycles, then give the sync path time
  task automatic pulse(input link_in_t m, input int n);
    @(posedge CLOCK);
    LINK_IN <= LINK_IN | m;
    repeat (n) @(posedge CLOCK);
    LINK_IN <= LINK_IN & ~m;
    repeat (4) @(posedge CLOCK);
  endtask : pulse
endmodule : usb_host_model

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import usb_power_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] e;} row_t;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic irq;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [3:0] ready = 4'h0;
  link_in_t link_in;
  link_in_t m;
  link_out_t link_out;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  row_t rows [4] = '{'{OFS_POWER, 8'h10}, '{OFS_IN_FLAGS, 8'h00},
    '{OFS_FRAME_HIGH, 8'h00}, '{8'h3F, 8'h00}};
  always #20 clock = ~clock;
  usb_power_frame_irq_ctrl usb_power_frame_irq_ctrl_inst (.CLOCK(clock), .RESET(reset),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IN_PACKET_READY(ready),
    .LINK_IN(link_in), .LINK_OUT(link_out), .IRQ(irq));
  usb_host_model usb_host_model_inst (.CLOCK(clock), .LINK_OUT(link_out), .LINK_IN(link_in));
  task automatic stop_test();
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr8
  task automatic rd8(input logic [7:0] a, input logic [7:0] e, input logic [7:0] k = 8'hFF);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata & k, e);
  endtask : rd8
  task automatic ev(input int f, input int n);
    m = '0;
    m[f] = 1'b1;
    usb_host_model_inst.pulse(m, n);
  endtask : ev
  task automatic tok(input logic [3:0] r, input logic [3:0] t);
    @(posedge clock);
    ready <= r;
    @(posedge clock);
    ready <= 4'h0;
    m = '0;
    m.in_token = t;
    usb_host_model_inst.pulse(m, 2);
  endtask : tok
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    foreach (rows[i]) rd8(rows[i].a, rows[i].e);
    m = '0;
    m.sof = 1'b1;
    m.frame = 11'h5A3;
    usb_host_model_inst.pulse(m, 2);
    rd8(OFS_FRAME_LOW, 8'h00);
    wr8(OFS_POWER, 8'h00);
    wr8(OFS_POWER, 8'h10);
    rd8(OFS_POWER, 8'h00);
    usb_host_model_inst.pulse(m, 2);
    rd8(OFS_FRAME_LOW, 8'hA3);
    rd8(OFS_FRAME_HIGH, 8'h05);
    tok(4'b0010, 4'b0010);
    chk({4'h0, usb_host_model_inst.got_data}, 8'h02);
    wr8(OFS_POWER, 8'h80);
    tok(4'b1100, 4'b0100);
    chk({4'h0, usb_host_model_inst.got_zero}, 8'h04);
    chk({4'h0, usb_host_model_inst.got_data}, 8'h02);
    ev(22, 2);
    tok(4'b0000, 4'b1100);
    chk({4'h0, usb_host_model_inst.got_data}, 8'h0E);
    ev(9, 2);
    rd8(OFS_POWER, 8'h80);
    wr8(OFS_POWER, 8'h81);
    ev(9, 2);
    rd8(OFS_POWER, 8'h83);
    rd8(OFS_COMMON, 8'h00, 8'h00);
    wr8(OFS_POWER, 8'h85);
    rd8(OFS_POWER, 8'h02, 8'h02);
    chk({7'h0, link_out.drive_resume}, 8'h01);
    wr8(OFS_POWER, 8'h81);
    rd8(OFS_POWER, 8'h81);
    chk({7'h0, irq}, 8'h01);
    rd8(OFS_COMMON, 8'h02, 8'h02);
    @(posedge clock);
    #1 chk({7'h0, irq}, 8'h00);
    ev(0, 2);
    ev(3, 2);
    rd8(OFS_IN_FLAGS, 8'h09);
    rd8(OFS_IN_FLAGS, 8'h00);
    ev(9, 2);
    ev(8, 2);
    rd8(OFS_POWER, 8'h02, 8'h02);
    rd8(OFS_COMMON, 8'h02, 8'h03);
    rd8(OFS_POWER, 8'h00, 8'h02);
    fork
      ev(10, 12);
      begin
        repeat (4) @(posedge clock);
        rd8(OFS_POWER, 8'h08, 8'h08);
      end
    join
    rd8(OFS_POWER, 8'h00, 8'h08);
    wr8(OFS_POWER, 8'h08);
    rd8(OFS_POWER, 8'h10);
    stop_test();
  end
endmodule : tb_top
